// file: core/lmb_pkg.sv
package lmb_pkg;

	localparam int LMB_CLK_MHZ = 25;
	// one sixteenth of a memory cycle, in ns (two local-bus clocks per sixteenth)
	localparam int LMB_SIXTEENTH_NS = 80;
	localparam int LMB_SIXTEENTH_CYCLES = (LMB_SIXTEENTH_NS * LMB_CLK_MHZ) / 1000;

	localparam int LMB_ADDR_W = 21;
	localparam int LMB_DATA_W = 16;
	localparam int LMB_SLOT_W = 4;
	localparam logic [3:0] LMB_SLOT_LAST = 4'hf;
	// row portion: slots 0..4 (5/16)
	localparam logic [3:0] LMB_ROW_LAST = 4'h4;
	// column portion: slots 5..7 (3/16)
	localparam logic [3:0] LMB_COL_FIRST = 4'h5;
	localparam logic [3:0] LMB_DATA_FIRST = 4'h8;
	localparam logic [3:0] LMB_ALE_LAST = 4'h3;
	localparam logic [3:0] LMB_RAS_FIRST = 4'h1;
	localparam logic [3:0] LMB_RAS_LAST = 4'he;
	localparam logic [3:0] LMB_CAS_LAST = 4'hd;
	localparam logic [3:0] LMB_BUF_FIRST = 4'h9;
	localparam logic [3:0] LMB_BUF_LAST = 4'he;
	localparam logic [3:0] LMB_WR_FIRST = 4'h9;
	localparam logic [3:0] LMB_WR_LAST = 4'hd;
	localparam logic [3:0] LMB_OE_LAST = 4'he;
	localparam logic [3:0] LMB_CAPTURE_SLOT = 4'he;

	localparam int LMB_A13_BIT = 13;
	localparam logic [4:0] LMB_EPROM_HI_SEG = 5'h1f;
	localparam logic [4:0] LMB_LOW_SEG = 5'h00;

	localparam logic [LMB_DATA_W-1:0] LMB_DATA_RST = 16'h0000;

	typedef struct packed {
		logic [LMB_ADDR_W-1:0] addr;
		logic write;
		logic refresh;
		logic [LMB_DATA_W-1:0] wdata;
	} lmb_req_type;

	typedef struct packed {
		logic bus_direction;
		logic buffer_enable_n;
		logic dram_output_enable_n;
		logic row_strobe_n;
		logic column_strobe_n;
		logic refresh_active;
		logic rom_select_n;
		logic address_latch_strobe;
		logic write_strobe_n;
	} lmb_pins_type;

	localparam lmb_pins_type LMB_PINS_IDLE = '{
		bus_direction: 1'b0, buffer_enable_n: 1'b1, dram_output_enable_n: 1'b1,
		row_strobe_n: 1'b1, column_strobe_n: 1'b1, refresh_active: 1'b0,
		rom_select_n: 1'b1, address_latch_strobe: 1'b0, write_strobe_n: 1'b1};

	typedef enum logic [0:0] {
		LMB_IDLE = 1'b0,
		LMB_BUSY = 1'b1
	} lmb_state_type;

endpackage

// file: core/lmb_phase_gen.sv
`timescale 1ns/100ps
`default_nettype none
module lmb_phase_gen (
	input wire logic clock,
	input wire logic rst_n,
	output logic phaseTick
);
	logic [3:0] count_r;
	logic [3:0] count_nxt;
	logic wrap;

	assign wrap = (count_r == 4'(lmb_pkg::LMB_SIXTEENTH_CYCLES - 1));
	assign count_nxt = wrap ? 4'h0 : count_r + 4'h1;
	assign phaseTick = wrap;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= 4'h0;
		end else begin
			count_r <= count_nxt;
		end
	end
endmodule
`default_nettype wire

// file: core/lmb_strobe_gen.sv
// Summary of operation
// (RULE1) direction high for writes, low reads
// (RULE2) direction valid before buffer enable
// (RULE3) output enable low on DRAM reads
// (RULE4) output enable high on ROM reads
// (RULE5) row address occupies first five sixteenths
// (RULE6) row strobe low during row address
// (RULE7) row strobe low during refresh address
// (RULE8) refresh indicator high during refresh cycle
// (RULE9) board gates column strobe with refresh
// (RULE10) local reset low on soft/system reset
// (RULE11) ROM select is chip select early
// (RULE12) ROM select low for boot-range reads
// (RULE13) ROM select high for other accesses
// (RULE14) ROM select carries A13 later on
// (RULE15) write strobe low marks write cycle
// (RULE16) write data valid while strobe low
// (RULE17) DRAM falling, SRAM rising edge capture
// (RULE18) board leaves interrupt pin unconnected
// (RULE19) buffers enabled only in data phase
// (RULE20) column strobe after row, not ROM
// (RULE21) strobes change only on phase boundaries; code also moves them on any clock while reset is active
`timescale 1ns/100ps
`default_nettype none
module lmb_strobe_gen (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic system_reset_in,
	input wire logic soft_adapter_reset_bit,
	input wire logic bootBit,
	input wire logic reqValid,
	output logic reqReady,
	input wire lmb_pkg::lmb_req_type req,
	output lmb_pkg::lmb_pins_type pins,
	output logic local_bus_reset_n,
	input wire logic [7:0] data_high_byte_in,
	input wire logic [7:0] data_low_byte_in,
	output logic [7:0] data_high_byte_out,
	output logic [7:0] data_low_byte_out,
	output logic dataOe,
	output logic [15:0] readData,
	output logic readValid
);
	logic phaseTick;
	logic sysMeta_r;
	logic sysSync_r;
	logic [15:0] rdMeta_r;
	logic [15:0] rdSync_r;
	logic resetActive_r;
	lmb_pkg::lmb_state_type state_r;
	lmb_pkg::lmb_state_type state_nxt;
	logic [3:0] slot_r;
	logic [3:0] slot_nxt;
	lmb_pkg::lmb_req_type cyc_r;
	lmb_pkg::lmb_req_type cyc_nxt;
	lmb_pkg::lmb_pins_type pins_r;
	lmb_pkg::lmb_pins_type pins_nxt;
	logic dataOe_r;
	logic dataOe_nxt;
	logic [15:0] readData_r;
	logic readValid_r;
	logic accept;
	logic lastSlot;
	logic busyNext;
	logic isWrite;
	logic isRead;
	logic isRefresh;
	logic idRange;
	logic epromRange;
	logic romAny;
	logic rowPhase;
	logic inRas;
	logic inCas;
	logic inBuf;
	logic inWr;
	logic inOe;
	logic capture;

	lmb_phase_gen phase_gen (
		.clock(clock),
		.rst_n(rst_n),
		.phaseTick(phaseTick)
	);

	// pins from outside pass two flops before use
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sysMeta_r <= 1'b0;
			sysSync_r <= 1'b0;
			rdMeta_r <= lmb_pkg::LMB_DATA_RST;
			rdSync_r <= lmb_pkg::LMB_DATA_RST;
		end else begin
			sysMeta_r <= system_reset_in;
			sysSync_r <= sysMeta_r;
			rdMeta_r <= {data_high_byte_in, data_low_byte_in};
			rdSync_r <= rdMeta_r;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			resetActive_r <= 1'b1;
		end else begin
			resetActive_r <= soft_adapter_reset_bit | sysSync_r; // RULE10
		end
	end
	assign local_bus_reset_n = ~resetActive_r; // RULE10

	// sequencer: a new cycle may start right after slot 15, so cycles run back to back
	assign lastSlot = (slot_r == lmb_pkg::LMB_SLOT_LAST);
	assign reqReady = phaseTick & ~resetActive_r & ((state_r == lmb_pkg::LMB_IDLE) | lastSlot);
	assign accept = reqValid & reqReady;
	assign cyc_nxt = accept ? req : cyc_r;

	always_comb begin
		state_nxt = state_r;
		slot_nxt = slot_r;
		if (resetActive_r) begin
			state_nxt = lmb_pkg::LMB_IDLE;
			slot_nxt = 4'h0;
		end else if (phaseTick) begin
			case (state_r)
				lmb_pkg::LMB_IDLE: begin
					if (accept) begin
						state_nxt = lmb_pkg::LMB_BUSY;
					end
					slot_nxt = 4'h0;
				end
				lmb_pkg::LMB_BUSY: begin
					if (lastSlot) begin
						state_nxt = accept ? lmb_pkg::LMB_BUSY : lmb_pkg::LMB_IDLE;
						slot_nxt = 4'h0;
					end else begin
						slot_nxt = slot_r + 4'h1;
					end
				end
				default: begin
					state_nxt = lmb_pkg::LMB_IDLE;
					slot_nxt = 4'h0;
				end
			endcase
		end
	end

	// decode for the slot about to start
	assign busyNext = (state_nxt == lmb_pkg::LMB_BUSY);
	assign isRefresh = busyNext & cyc_nxt.refresh;
	assign isWrite = busyNext & cyc_nxt.write & ~cyc_nxt.refresh;
	assign isRead = busyNext & ~cyc_nxt.write & ~cyc_nxt.refresh;
	assign idRange = (cyc_nxt.addr[20:4] == 17'h00000);
	assign epromRange = ~bootBit & ~idRange & ((cyc_nxt.addr[20:16] == lmb_pkg::LMB_LOW_SEG)
		| (cyc_nxt.addr[20:16] == lmb_pkg::LMB_EPROM_HI_SEG));
	assign romAny = idRange | epromRange;
	assign rowPhase = (slot_nxt <= lmb_pkg::LMB_ROW_LAST); // RULE5
	assign inRas = (slot_nxt >= lmb_pkg::LMB_RAS_FIRST) & (slot_nxt <= lmb_pkg::LMB_RAS_LAST);
	assign inCas = (slot_nxt >= lmb_pkg::LMB_COL_FIRST) & (slot_nxt <= lmb_pkg::LMB_CAS_LAST);
	assign inBuf = (slot_nxt >= lmb_pkg::LMB_BUF_FIRST) & (slot_nxt <= lmb_pkg::LMB_BUF_LAST);
	assign inWr = (slot_nxt >= lmb_pkg::LMB_WR_FIRST) & (slot_nxt <= lmb_pkg::LMB_WR_LAST);
	assign inOe = (slot_nxt >= lmb_pkg::LMB_DATA_FIRST) & (slot_nxt <= lmb_pkg::LMB_OE_LAST);

	// direction set from slot 0, buffers only from slot 9, so it leads them
	assign pins_nxt.bus_direction = isWrite; // RULE1 RULE2
	assign pins_nxt.buffer_enable_n = ~((isWrite | isRead) & inBuf); // RULE19
	assign pins_nxt.dram_output_enable_n = ~(isRead & ~romAny & inOe); // RULE3 RULE4
	assign pins_nxt.row_strobe_n = ~(busyNext & inRas); // RULE6 RULE7
	// refresh: column strobe leads row strobe for column-before-row parts
	assign pins_nxt.column_strobe_n = ~((isRefresh & (slot_nxt <= lmb_pkg::LMB_CAS_LAST))
		| ((isRead | isWrite) & ~romAny & inCas)); // RULE20
	assign pins_nxt.refresh_active = isRefresh; // RULE8
	assign pins_nxt.rom_select_n = rowPhase ? ~(isRead & epromRange) // RULE11 RULE12 RULE13
		: (busyNext ? cyc_nxt.addr[lmb_pkg::LMB_A13_BIT] : 1'b1); // RULE14
	assign pins_nxt.address_latch_strobe = busyNext & ~isRefresh
		& (slot_nxt <= lmb_pkg::LMB_ALE_LAST);
	assign pins_nxt.write_strobe_n = ~(isWrite & inWr); // RULE15
	// data driven from slot 8 to 15, wider than the strobe on both sides
	assign dataOe_nxt = isWrite & (slot_nxt >= lmb_pkg::LMB_DATA_FIRST); // RULE16
	assign capture = phaseTick & isRead & (slot_nxt == lmb_pkg::LMB_CAPTURE_SLOT);

	// all pins move only on the sixteenth tick, or on any clock while reset is active
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= lmb_pkg::LMB_IDLE;
			slot_r <= 4'h0;
			cyc_r <= '0;
			pins_r <= lmb_pkg::LMB_PINS_IDLE;
			dataOe_r <= 1'b0;
		end else if (phaseTick | resetActive_r) begin
			state_r <= state_nxt;
			slot_r <= slot_nxt;
			cyc_r <= cyc_nxt;
			pins_r <= pins_nxt; // RULE21
			dataOe_r <= dataOe_nxt;
		end
	end

	// sample late in the data phase; the sync lag stays inside the OE window
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			readData_r <= lmb_pkg::LMB_DATA_RST;
			readValid_r <= 1'b0;
		end else begin
			readValid_r <= capture;
			if (capture) begin
				readData_r <= rdSync_r;
			end
		end
	end

	assign pins = pins_r;
	assign dataOe = dataOe_r;
	assign data_high_byte_out = cyc_r.wdata[15:8];
	assign data_low_byte_out = cyc_r.wdata[7:0];
	assign readData = readData_r;
	assign readValid = readValid_r;

	logic busy;
	// slot one clock late, so a skipped slot is visible
	logic [3:0] prevSlot_r;
	assign busy = (state_r == lmb_pkg::LMB_BUSY);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prevSlot_r <= 4'h0;
		end else begin
			prevSlot_r <= slot_r;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	AST_DIR_WRITE: assert property (busy & cyc_r.write & ~cyc_r.refresh // RULE1
		|-> pins.bus_direction) else $error("direction low in write cycle");
	AST_DIR_LEADS: assert property ($fell(pins.buffer_enable_n) // RULE2
		|-> $past(pins.bus_direction) == pins.bus_direction) else $error("direction changed at enable");
	AST_OE_DRAM: assert property (busy & ~cyc_r.write & ~cyc_r.refresh // RULE3
		& (cyc_r.addr[20:16] == 5'h01) & (slot_r == 4'ha) |-> !pins.dram_output_enable_n)
		else $error("output enable high on dram read");
	AST_OE_ROM: assert property (busy & (cyc_r.addr[20:4] == 17'h00000) // RULE4
		|-> pins.dram_output_enable_n) else $error("output enable low on rom read");
	AST_RAS_ROW: assert property (busy & (slot_r >= 4'h1) & (slot_r <= 4'h4) // RULE6
		|-> !pins.row_strobe_n) else $error("row strobe high during row address");
	AST_REFRESH: assert property (pins.refresh_active |-> busy & cyc_r.refresh) // RULE8
		else $error("refresh indicator outside refresh");
	AST_LOCAL_RESET: assert property ($rose(sysSync_r) |=> !local_bus_reset_n) // RULE10
		else $error("local reset not asserted");
	AST_ROM_SEL: assert property (busy & cyc_r.write & (slot_r <= 4'h4) // RULE13
		|-> pins.rom_select_n) else $error("rom select low on write");
	AST_ROM_A13: assert property (busy & (slot_r >= 4'h5) // RULE14
		|-> pins.rom_select_n == cyc_r.addr[13]) else $error("rom select not address bit");
	AST_WR_DATA: assert property (!pins.write_strobe_n |-> dataOe) // RULE16
		else $error("write data not driven under strobe");
	AST_WR_WIDTH: assert property ($fell(pins.write_strobe_n) // RULE15
		|-> !pins.write_strobe_n [*8]) else $error("write strobe too short");
	AST_PHASE_ONLY: assert property (!phaseTick & !resetActive_r // RULE21
		|=> $stable(pins)) else $error("strobe moved off a phase boundary");

	AST_DIR_READ: assert property (busy & ~cyc_r.write // RULE1
		|-> !pins.bus_direction)
		else $error("direction high in read cycle");
	AST_OE_WRITE: assert property (busy & cyc_r.write // RULE3
		|-> pins.dram_output_enable_n)
		else $error("output enable low on write");
	AST_ROW_NO_CAS: assert property (busy & ~cyc_r.refresh & (slot_r <= 4'h4) // RULE5
		|-> pins.column_strobe_n)
		else $error("column strobe inside row portion");
	AST_RAS_REFRESH: assert property (busy & cyc_r.refresh // RULE7
		& (slot_r >= 4'h1) & (slot_r <= 4'h4) |-> !pins.row_strobe_n)
		else $error("row strobe high in refresh");
	AST_REF_LOW: assert property (busy & ~cyc_r.refresh // RULE8
		|-> !pins.refresh_active)
		else $error("refresh indicator in normal cycle");
	AST_SOFT_RESET: assert property (soft_adapter_reset_bit // RULE10
		|=> !local_bus_reset_n)
		else $error("local reset missed soft bit");
	// boot bit is taken to move only between cycles
	AST_ROM_CS: assert property (busy & ~cyc_r.write & ~cyc_r.refresh // RULE11 RULE12
		& ~bootBit & (cyc_r.addr[20:16] == 5'h1f) & (slot_r <= 4'h4)
		|-> !pins.rom_select_n) else $error("rom select high on eprom read");
	AST_ROM_BOOT: assert property (bootBit & busy & (slot_r <= 4'h4) // RULE13
		|-> pins.rom_select_n)
		else $error("rom select low with boot bit set");
	AST_WR_IDLE: assert property (busy & ~cyc_r.write // RULE15
		|-> pins.write_strobe_n)
		else $error("write strobe low outside write");
	AST_BUF_DATA: assert property (!pins.buffer_enable_n // RULE19
		|-> busy & ~cyc_r.refresh & (slot_r >= 4'h9))
		else $error("buffers on outside data phase");
	AST_CAS_ROM: assert property (busy & ~cyc_r.refresh // RULE20
		& (cyc_r.addr[20:4] == 17'h00000) |-> pins.column_strobe_n)
		else $error("column strobe on identity rom");
	AST_SLOT_STEP: assert property ((slot_r != prevSlot_r) // RULE21
		|-> (slot_r == prevSlot_r + 4'h1) | (slot_r == 4'h0))
		else $error("slot skipped");

	COV_READ: cover property (busy & isRead & (slot_r == 4'hf));
	COV_WRITE: cover property ($rose(pins.write_strobe_n));
	COV_REFRESH: cover property ($rose(pins.refresh_active));
	COV_BACK2BACK: cover property (busy & lastSlot & accept);
	COV_ROM_READ: cover property (busy & ~cyc_r.write & !pins.rom_select_n);
endmodule
`default_nettype wire

// file: test/lmb_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module lmb_mem_model #(
	parameter logic [15:0] ROM_WORD = 16'h5aa5
) (
	input wire lmb_pkg::lmb_pins_type pins,
	input wire logic [7:0] hiOut,
	input wire logic [7:0] loOut,
	output logic [7:0] hiIn,
	output logic [7:0] loIn
);
	logic [15:0] dramWord = 16'h0000;
	logic [15:0] lastWord = 16'h0000;
	// old DRAMs see no column strobe while refresh runs
	wire casGated = pins.column_strobe_n | pins.refresh_active;
	// DRAM takes data as the write strobe falls
	always @(negedge pins.write_strobe_n) begin
		if (!casGated)
			dramWord <= {hiOut, loOut};
	end
	// released bus shows the inverse, never a stale copy
	always @(pins, dramWord) begin
		if (!pins.buffer_enable_n && !pins.bus_direction) begin
			lastWord = pins.dram_output_enable_n ? ROM_WORD : dramWord;
			{hiIn, loIn} = lastWord;
		end else begin
			{hiIn, loIn} = ~lastWord;
		end
	end
	// no interrupt pin modelled: left open
endmodule
`default_nettype wire

// file: test/local_memory_bus_strobes_tb.sv
`timescale 1ns/100ps
`default_nettype none
module local_memory_bus_strobes_tb;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic sysRst = 1'b0;
	logic softRst = 1'b0;
	logic bootBit = 1'b0;
	logic reqValid = 1'b0;
	logic reqReady;
	lmb_pkg::lmb_req_type req = '0;
	lmb_pkg::lmb_pins_type pins;
	logic localRst_n;
	logic [7:0] hiIn, loIn, hiOut, loOut;
	logic dataOe;
	logic [15:0] readData;
	logic readValid;
	int n_fail = 0;
	int n_checks = 0;
	localparam logic [15:0] ROMW = 16'h5aa5;
	always #20 clock = ~clock;
	lmb_strobe_gen DUT (.clock(clock), .rst_n(rst_n), .system_reset_in(sysRst),
		.soft_adapter_reset_bit(softRst), .bootBit(bootBit), .reqValid(reqValid),
		.reqReady(reqReady), .req(req), .pins(pins), .local_bus_reset_n(localRst_n),
		.data_high_byte_in(hiIn), .data_low_byte_in(loIn), .data_high_byte_out(hiOut),
		.data_low_byte_out(loOut), .dataOe(dataOe), .readData(readData),
		.readValid(readValid));
	lmb_mem_model #(.ROM_WORD(ROMW)) mem (.pins(pins), .hiOut(hiOut), .loOut(loOut),
		.hiIn(hiIn), .loIn(loIn));
	task automatic check(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	// kinds: 0 dram read, 1 write, 2 eprom read, 3 identity read, 4 refresh, 5 rom write
	function automatic lmb_pkg::lmb_pins_type expect_pins(int kind, logic a13, int k);
		lmb_pkg::lmb_pins_type p;
		p = lmb_pkg::LMB_PINS_IDLE;
		p.row_strobe_n = !(k >= 1 && k <= 14);
		p.address_latch_strobe = kind != 4 && k <= 3;
		p.bus_direction = kind == 1 || kind == 5;
		p.column_strobe_n = !((kind == 4 && k <= 13) || (kind < 2 && k >= 5 && k <= 13));
		p.dram_output_enable_n = !(kind == 0 && k >= 8 && k <= 14);
		p.buffer_enable_n = !(kind != 4 && k >= 9 && k <= 14);
		p.write_strobe_n = !((kind == 1 || kind == 5) && k >= 9 && k <= 13);
		p.refresh_active = kind == 4;
		p.rom_select_n = (k >= 5) ? a13 : !(kind == 2);
		return p;
	endfunction
	task automatic do_cycle(input int kind, input logic [20:0] a, input logic [15:0] d);
		int n;
		int rv;
		logic isRead;
		isRead = kind == 0 || kind == 2 || kind == 3;
		@(negedge clock);
		req.addr = a;
		req.write = kind == 1 || kind == 5;
		req.refresh = kind == 4;
		req.wdata = d;
		reqValid = 1'b1;
		n = 0;
		while (reqReady !== 1'b1 && n < 100) begin
			@(negedge clock);
			n++;
		end
		check(n < 100, "request never taken");
		@(negedge clock);
		reqValid = 1'b0;
		rv = 0;
		// every clock of a slot checked: strobes only move on slot edges
		for (int i = 0; i < 32; i++) begin
			check(pins === expect_pins(kind, a[13], i / 2), "strobe pattern");
			if (pins.write_strobe_n === 1'b0)
				check({hiOut, loOut} === d && dataOe === 1'b1, "write data");
			if (readValid === 1'b1) begin
				rv++;
				check(readData === d, "read data");
			end
			@(negedge clock);
		end
		check(rv == (isRead ? 1 : 0), "read pulse count");
	endtask
	task automatic test_write;
		do_cycle(1, 21'h100000, 16'h1234);
		$display("test_write done");
	endtask
	task automatic test_dram_read;
		do_cycle(0, 21'h01a000, 16'h1234);
		$display("test_dram_read done");
	endtask
	task automatic test_rom_read;
		do_cycle(2, 21'h1f2000, ROMW);
		do_cycle(2, 21'h000010, ROMW);
		do_cycle(3, 21'h00000f, ROMW);
		$display("test_rom_read done");
	endtask
	task automatic test_rom_off;
		do_cycle(5, 21'h00e000, 16'hbeef);
		bootBit = 1'b1;
		do_cycle(0, 21'h00ff00, 16'h1234);
		bootBit = 1'b0;
		$display("test_rom_off done");
	endtask
	task automatic test_refresh;
		do_cycle(4, 21'h002000, 16'h0000);
		$display("test_refresh done");
	endtask
	task automatic test_reset;
		@(negedge clock);
		softRst = 1'b1;
		repeat (2) @(negedge clock);
		check(localRst_n === 1'b0 && pins === lmb_pkg::LMB_PINS_IDLE, "soft reset");
		softRst = 1'b0;
		repeat (2) @(negedge clock);
		check(localRst_n === 1'b1, "soft release");
		sysRst = 1'b1;
		repeat (5) @(negedge clock);
		check(localRst_n === 1'b0, "system reset");
		sysRst = 1'b0;
		repeat (5) @(negedge clock);
		check(localRst_n === 1'b1, "system release");
		$display("test_reset done");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clock);
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
		test_write;
		test_dram_read;
		test_rom_read;
		test_rom_off;
		test_refresh;
		test_reset;
		test_dram_read;
		finish_test;
	end
	// whole run is under 500 clocks; generous margin
	initial begin
		#400000;
		n_fail++;
		finish_test;
	end
endmodule
`default_nettype wire
